// ==== logic/lcd_command_decoder.sv ====
// How it works
// - bit6 zero loads data pointer 0..39
// - 1100 prefix loads subaddress counter
// - bank-select bit1 picks input RAM bank
// - bank-select bit0 picks output RAM bank
// - bank-select ignored in 1:3, 1:4
// - 1110 prefix sets blink frequency field
// - blink bit2 selects alternate bank blinking
// - 1:3 and 1:4 force normal blinking
// - controller executes and holds decoded settings
// - data bytes fill RAM per drive mode
// - bit7 clear switches to display data
// - mode-set low bits give drive mode
// - store at pointer, auto-advance pointer, subaddress
`timescale 1ns/1ps
`default_nettype none

module lcd_command_decoder (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    // Bytes from the bus slave, same clock
    input  wire logic        rx_start,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_byte,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Display settings and write busy flag
    output logic [1:0]       drive_mode,
    output logic [1:0]       blink_rate_field,
    output logic             blink_style_bit,
    output logic             out_bank,
    output logic             wr_busy
);

    // ======================================================
    // State
    logic [3:0]  ram [lcd_pkg::RAM_DEPTH];
    logic        ctrl_en, next_ctrl_en;
    logic [2:0]  own_sub, next_own_sub;
    logic [5:0]  ram_addr, next_ram_addr;
    logic        cmd_phase, next_cmd_phase;
    logic [5:0]  ptr, next_ptr;
    logic [2:0]  sub, next_sub;
    logic [1:0]  col, next_col;
    logic [1:0]  mode, next_mode;
    logic        in_bank, next_in_bank;
    logic        out_req, next_out_req;
    logic [1:0]  rate, next_rate;
    logic        style, next_style;
    logic [7:0]  shreg, next_shreg;
    logic [2:0]  bitcnt, next_bitcnt;
    lcd_pkg::lcd_wstate_t wst, next_wst;
    logic        next_pready, next_pslverr;
    logic [31:0] next_prdata;
    logic        mux_mode, next_mux_mode, bank_ok;
    logic        wr_en;
    logic [1:0]  last_col, wr_pos;
    logic        cmd_take, data_take, apb_wr;
    logic [3:0]  ram_word;

    assign mux_mode  = (mode == lcd_pkg::MODE_MUX3) || (mode == lcd_pkg::MODE_MUX4);
    assign bank_ok   = !mux_mode;
    assign cmd_take  = rx_valid && cmd_phase && (wst == lcd_pkg::LCD_IDLE);
    assign data_take = rx_valid && !cmd_phase && (wst == lcd_pkg::LCD_IDLE);
    assign apb_wr    = psel && penable && pready && pwrite;
    assign ram_word  = (ram_addr <= lcd_pkg::PTR_LAST) ? ram[ram_addr] : 4'h0;

    // Bits stored per RAM address for each drive mode
    always_comb begin
        unique case (mode)
            lcd_pkg::MODE_STATIC: last_col = 2'h0;
            lcd_pkg::MODE_MUX2:   last_col = 2'h1;
            lcd_pkg::MODE_MUX3:   last_col = 2'h2;
            lcd_pkg::MODE_MUX4:   last_col = 2'h3;
        endcase
    end

    // ======================================================
    // Command decode and RAM filling
    always_comb begin
        next_cmd_phase = cmd_phase;
        next_ptr       = ptr;
        next_sub       = sub;
        next_col       = col;
        next_mode      = mode;
        next_in_bank   = in_bank;
        next_out_req   = out_req;
        next_rate      = rate;
        next_style     = style;
        next_shreg     = shreg;
        next_bitcnt    = bitcnt;
        next_wst       = wst;
        wr_en          = 1'b0;
        // Only static and 1:2 have room for a second bank in each word
        wr_pos         = col + ((bank_ok && in_bank) ? 2'h2 : 2'h0);
        if (rx_start && wst == lcd_pkg::LCD_IDLE) begin
            next_cmd_phase = 1'b1;
        end else if (cmd_take && ctrl_en) begin
            next_cmd_phase = rx_byte[7];
            if (!rx_byte[6]) begin
                // Out-of-range pointer values are dropped
                if (rx_byte[5:0] <= lcd_pkg::PTR_LAST) begin
                    next_ptr = rx_byte[5:0];
                    next_col = 2'h0;
                end
            end else if (rx_byte[6:5] == lcd_pkg::OP_MODE_SET) begin
                next_mode = rx_byte[1:0];
            end else if (rx_byte[6:3] == lcd_pkg::OP_SUBADDR) begin
                next_sub = rx_byte[2:0];
            end else if (rx_byte[6:2] == lcd_pkg::OP_BANK) begin
                if (bank_ok) begin
                    next_in_bank = rx_byte[1];
                    next_out_req = rx_byte[0];
                end
            end else if (rx_byte[6:3] == lcd_pkg::OP_BLINK) begin
                next_rate  = rx_byte[1:0];
                next_style = rx_byte[2];
            end
        end else if (data_take && ctrl_en) begin
            next_shreg  = rx_byte;
            next_bitcnt = 3'h0;
            next_wst    = lcd_pkg::LCD_WRITE;
        end else if (wst == lcd_pkg::LCD_WRITE) begin
            // One bit per cycle, MSB first; the bus gives far more time per byte
            wr_en      = (sub == own_sub);
            next_shreg = {shreg[6:0], 1'b0};
            if (col == last_col) begin
                next_col = 2'h0;
                if (ptr == lcd_pkg::PTR_LAST) begin
                    next_ptr = 6'h0;
                    next_sub = sub + 3'h1;
                end else begin
                    next_ptr = ptr + 6'h1;
                end
            end else begin
                next_col = col + 2'h1;
            end
            next_bitcnt = bitcnt + 3'h1;
            if (bitcnt == lcd_pkg::BITS_PER_BYTE_M1) begin
                next_wst = lcd_pkg::LCD_IDLE;
            end
        end
    end

    assign next_mux_mode = (next_mode == lcd_pkg::MODE_MUX3) ||
                           (next_mode == lcd_pkg::MODE_MUX4);

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cmd_phase        <= 1'b0;
            ptr              <= 6'h0;
            sub              <= 3'h0;
            col              <= 2'h0;
            mode             <= lcd_pkg::MODE_RST;
            in_bank          <= 1'b0;
            out_req          <= 1'b0;
            rate             <= 2'h0;
            style            <= 1'b0;
            shreg            <= 8'h0;
            bitcnt           <= 3'h0;
            wst              <= lcd_pkg::LCD_IDLE;
            drive_mode       <= lcd_pkg::MODE_RST;
            blink_rate_field <= 2'h0;
            blink_style_bit  <= 1'b0;
            out_bank         <= 1'b0;
            wr_busy          <= 1'b0;
        end else begin
            cmd_phase        <= next_cmd_phase;
            ptr              <= next_ptr;
            sub              <= next_sub;
            col              <= next_col;
            mode             <= next_mode;
            in_bank          <= next_in_bank;
            out_req          <= next_out_req;
            rate             <= next_rate;
            style            <= next_style;
            shreg            <= next_shreg;
            bitcnt           <= next_bitcnt;
            wst              <= next_wst;
            drive_mode       <= next_mode;
            blink_rate_field <= next_rate;
            blink_style_bit  <= next_style && !next_mux_mode;
            out_bank         <= next_out_req && !next_mux_mode;
            wr_busy          <= (next_wst == lcd_pkg::LCD_WRITE);
        end
    end

    // RAM has no reset; software must fill it before enabling the display
    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            ram[ptr][wr_pos] <= shreg[7];
        end
    end

    // ======================================================
    // APB slave: one-cycle access phase, no wait states
    always_comb begin
        next_ctrl_en  = ctrl_en;
        next_own_sub  = own_sub;
        next_ram_addr = ram_addr;
        next_pready   = psel && !penable && !pready;
        next_pslverr  = 1'b0;
        next_prdata   = 32'h0;
        if (psel && !penable) begin
            unique case (paddr)
                lcd_pkg::OFS_CTRL: begin
                    next_prdata[lcd_pkg::CTRL_EN_POS]                     = ctrl_en;
                    next_prdata[lcd_pkg::CTRL_SUB_POS +: 3]               = own_sub;
                end
                lcd_pkg::OFS_STATUS: begin
                    next_prdata[lcd_pkg::ST_MODE_POS +: 2]  = mode;
                    next_prdata[lcd_pkg::ST_RATE_POS +: 2]  = rate;
                    next_prdata[lcd_pkg::ST_STYLE_POS]      = style;
                    next_prdata[lcd_pkg::ST_INBANK_POS]     = in_bank;
                    next_prdata[lcd_pkg::ST_OUTBANK_POS]    = out_req;
                    next_prdata[lcd_pkg::ST_CMD_POS]        = cmd_phase;
                    next_prdata[lcd_pkg::ST_SUB_POS +: 3]   = sub;
                    next_prdata[lcd_pkg::ST_PTR_POS +: 6]   = ptr;
                    next_prdata[lcd_pkg::ST_BUSY_POS]       = (wst == lcd_pkg::LCD_WRITE);
                end
                lcd_pkg::OFS_RAM_ADDR: next_prdata[5:0] = ram_addr;
                lcd_pkg::OFS_RAM_DATA: next_prdata[3:0] = ram_word;
                default:               next_pslverr     = 1'b1;
            endcase
        end
        if (apb_wr) begin
            unique case (paddr)
                lcd_pkg::OFS_CTRL: begin
                    next_ctrl_en = pwdata[lcd_pkg::CTRL_EN_POS];
                    next_own_sub = pwdata[lcd_pkg::CTRL_SUB_POS +: 3];
                end
                lcd_pkg::OFS_RAM_ADDR: next_ram_addr = pwdata[5:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_en  <= lcd_pkg::CTRL_EN_RST;
            own_sub  <= lcd_pkg::OWN_SUB_RST;
            ram_addr <= 6'h0;
            pready   <= 1'b0;
            pslverr  <= 1'b0;
            prdata   <= 32'h0;
        end else begin
            ctrl_en  <= next_ctrl_en;
            own_sub  <= next_own_sub;
            ram_addr <= next_ram_addr;
            pready   <= next_pready;
            pslverr  <= next_pslverr;
            prdata   <= next_prdata;
        end
    end

    // ======================================================
    // Assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    sequence s_data_byte;
        data_take && ctrl_en && !rx_start;
    endsequence

    sequence s_fill_byte;
        wr_busy [*8] ##1 !wr_busy;
    endsequence

    a_ptr_load: assert property (
        cmd_take && ctrl_en && !rx_start && !rx_byte[6] && rx_byte[5:0] <= 6'h27
        |=> ptr == $past(rx_byte[5:0]) && col == 2'h0)
        else $error("pointer not loaded by command");
    a_sub_load: assert property (
        cmd_take && ctrl_en && !rx_start && rx_byte[6:3] == 4'hc
        |=> sub == $past(rx_byte[2:0]))
        else $error("subaddress not loaded");
    a_bank_set: assert property (
        cmd_take && ctrl_en && !rx_start && rx_byte[6:2] == 5'h1e && !mux_mode
        |=> in_bank == $past(rx_byte[1]) && out_bank == $past(rx_byte[0]))
        else $error("bank select not applied");
    a_bank_ignore: assert property (
        cmd_take && ctrl_en && !rx_start && rx_byte[6:2] == 5'h1e && mux_mode
        |=> $stable(in_bank) && $stable(out_req))
        else $error("bank select acted in 1:3 or 1:4");
    a_blink_set: assert property (
        cmd_take && ctrl_en && !rx_start && rx_byte[6:3] == 4'he
        |=> blink_rate_field == $past(rx_byte[1:0]) && style == $past(rx_byte[2]))
        else $error("blink select not applied");
    a_blink_normal: assert property (
        (drive_mode == 2'h3 || drive_mode == 2'h0) |-> !blink_style_bit && !out_bank)
        else $error("alternate bank used in 1:3 or 1:4");
    a_mode_set: assert property (
        cmd_take && ctrl_en && !rx_start && rx_byte[6:5] == 2'h2
        |=> drive_mode == $past(rx_byte[1:0]))
        else $error("drive mode not taken");
    a_cont_flag: assert property (
        cmd_take && ctrl_en && !rx_start |=> cmd_phase == $past(rx_byte[7]))
        else $error("continuation flag not followed");
    a_fill_len: assert property (
        s_data_byte |=> s_fill_byte)
        else $error("data byte not written in eight steps");
    a_ptr_step: assert property (
        wr_busy && col == last_col && ptr != 6'h27 |=> ptr == $past(ptr) + 6'h1)
        else $error("pointer did not advance");

endmodule // lcd_command_decoder

`default_nettype wire

// ==== logic/lcd_pkg.sv ====
// ==========================================================
// Command decoder constants
`default_nettype none

package lcd_pkg;

    // ======================================================
    // APB register map (byte addresses)
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_STATUS   = 8'h04;
    localparam logic [7:0] OFS_RAM_ADDR = 8'h08;
    localparam logic [7:0] OFS_RAM_DATA = 8'h0c;

    // ======================================================
    // Field positions
    localparam int CTRL_EN_POS     = 0;
    localparam int CTRL_SUB_POS    = 1;
    localparam int ST_MODE_POS     = 0;
    localparam int ST_RATE_POS     = 2;
    localparam int ST_STYLE_POS    = 4;
    localparam int ST_INBANK_POS   = 5;
    localparam int ST_OUTBANK_POS  = 6;
    localparam int ST_CMD_POS      = 7;
    localparam int ST_SUB_POS      = 8;
    localparam int ST_PTR_POS      = 11;
    localparam int ST_BUSY_POS     = 17;

    // ======================================================
    // Reset values
    localparam logic       CTRL_EN_RST  = 1'b1;
    localparam logic [2:0] OWN_SUB_RST  = 3'h0;
    localparam logic [1:0] MODE_RST     = 2'h0;

    // ======================================================
    // Display RAM and command fields
    localparam int         RAM_DEPTH    = 40;
    localparam logic [5:0] PTR_LAST     = 6'h27;
    localparam logic [1:0] MODE_STATIC  = 2'h1;
    localparam logic [1:0] MODE_MUX2    = 2'h2;
    localparam logic [1:0] MODE_MUX3    = 2'h3;
    localparam logic [1:0] MODE_MUX4    = 2'h0;
    localparam logic [1:0] OP_MODE_SET  = 2'h2;
    localparam logic [3:0] OP_SUBADDR   = 4'hc;
    localparam logic [4:0] OP_BANK      = 5'h1e;
    localparam logic [3:0] OP_BLINK     = 4'he;
    localparam logic [2:0] BITS_PER_BYTE_M1 = 3'h7;

    typedef enum logic {LCD_IDLE, LCD_WRITE} lcd_wstate_t;

endpackage

`default_nettype wire

// ==== bench/lcd_byte_src.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Bus controller model: hands received bytes to the decoder
module lcd_byte_src (
    // Clock
    input  wire logic       ref_clk,
    // Byte stream towards the decoder
    output logic            rx_start,
    output logic            rx_valid,
    output logic [7:0]      rx_byte
);
    logic cmd_phase;

    initial begin
        rx_start  = 1'b0;
        rx_valid  = 1'b0;
        rx_byte   = 8'h00;
        cmd_phase = 1'b0;
    end

    // New transfer: the first byte after it is a command
    task automatic start_xfer();
        @(posedge ref_clk);
        rx_start  <= 1'b1;
        cmd_phase = 1'b1;
        @(posedge ref_clk);
        rx_start  <= 1'b0;
    endtask

    // One acknowledged byte, a single-cycle strobe
    task automatic put(input logic [7:0] b);
        @(posedge ref_clk);
        rx_valid <= 1'b1;
        rx_byte  <= b;
        @(posedge ref_clk);
        rx_valid <= 1'b0;
        // Released lines show the inverse so stale data never looks valid
        rx_byte  <= ~b;
        if (cmd_phase && !b[7]) begin
            cmd_phase = 1'b0;
        end
    endtask
endmodule // lcd_byte_src

`default_nettype wire

// ==== bench/tb_lcd_command_decoder.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_lcd_command_decoder;
    logic        ref_clk, reset_n;
    logic        rx_start, rx_valid;
    logic [7:0]  rx_byte, paddr;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [31:0] pwdata, prdata, rdat;
    logic [1:0]  drive_mode, blink_rate_field;
    logic        blink_style_bit, out_bank, wr_busy, rerr;
    int          err_count, n_tests, cyc;

    lcd_byte_src lcd_byte_src_i (.ref_clk(ref_clk), .rx_start(rx_start), .rx_valid(rx_valid),
                                 .rx_byte(rx_byte));
    lcd_command_decoder lcd_command_decoder_i (
        .ref_clk(ref_clk), .reset_n(reset_n), .rx_start(rx_start), .rx_valid(rx_valid),
        .rx_byte(rx_byte), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .drive_mode(drive_mode), .blink_rate_field(blink_rate_field),
        .blink_style_bit(blink_style_bit), .out_bank(out_bank), .wr_busy(wr_busy));

    // ======================================================
    // Clock and hang guard
    initial ref_clk = 1'b0;
    always #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            final_report();
        end
    end

    // ======================================================
    // Helpers
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Zero wait states are not assumed: wait for pready under a bound
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge ref_clk);
        end
        if (n == 50) err_count++;
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic send(input logic [7:0] b);
        lcd_byte_src_i.put(b);
        #1;
    endtask

    // Data bytes keep the fill busy; the next byte waits for it to end
    task automatic fill_wait();
        int n;
        n = 0;
        while (wr_busy === 1'b1 && n < 20) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        chk("busy_len", 32'd8, n);
    endtask

    task automatic status();
        apb(1'b0, lcd_pkg::OFS_STATUS, 32'h0);
    endtask

    // ======================================================
    // Main sequence
    initial begin
        {reset_n, psel, penable, pwrite} = 4'h0;
        {paddr, pwdata} = '0;
        {err_count, n_tests, cyc} = '0;
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        apb(1'b0, lcd_pkg::OFS_CTRL, 32'h0);
        chk("ctrl_rst", 32'h1, rdat);
        status();
        chk("status_rst", 32'h0, rdat);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, rerr});
        chk("unmapped_data", 32'h0, rdat);
        lcd_byte_src_i.start_xfer();
        for (int m = 0; m < 4; m++) begin
            send(8'hc0 | 8'(m));
            chk("drive_mode", 32'(m), {30'h0, drive_mode});
        end
        send(8'hc1);
        send(8'hfb);
        chk("out_bank", 32'h1, {31'h0, out_bank});
        for (int r = 0; r < 4; r++) begin
            send(8'hf4 | 8'(r));
            chk("blink_rate", 32'(r), {30'h0, blink_rate_field});
            chk("blink_style", 32'h1, {31'h0, blink_style_bit});
        end
        send(8'hc3);
        chk("style_mux3", 32'h0, {31'h0, blink_style_bit});
        send(8'hf8);
        status();
        chk("in_bank_kept", 32'h1, {31'h0, rdat[lcd_pkg::ST_INBANK_POS]});
        chk("out_bank_kept", 32'h1, {31'h0, rdat[lcd_pkg::ST_OUTBANK_POS]});
        send(8'hc1);
        chk("out_bank_back", 32'h1, {31'h0, out_bank});
        send(8'hf8);
        send(8'he3);
        status();
        chk("subaddr", 32'h3, {29'h0, rdat[lcd_pkg::ST_SUB_POS +: 3]});
        send(8'he0);
        send(8'h85);
        send(8'ha8);
        status();
        chk("ptr_load", 32'h5, {26'h0, rdat[lcd_pkg::ST_PTR_POS +: 6]});
        chk("cmd_on", 32'(lcd_byte_src_i.cmd_phase), 32'(rdat[lcd_pkg::ST_CMD_POS]));
        send(8'h00);
        send(8'ha5);
        fill_wait();
        status();
        chk("ptr_adv", 32'h8, {26'h0, rdat[lcd_pkg::ST_PTR_POS +: 6]});
        chk("cmd_off", 32'(lcd_byte_src_i.cmd_phase), 32'(rdat[lcd_pkg::ST_CMD_POS]));
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, lcd_pkg::OFS_RAM_ADDR, 32'(i));
            apb(1'b0, lcd_pkg::OFS_RAM_DATA, 32'h0);
            chk("ram_bit", 32'((8'ha5 >> (7 - i)) & 8'h1), rdat & 32'h1);
        end
        // Wrap past word 39 moves to the next subaddress, which is not ours
        lcd_byte_src_i.start_xfer();
        send(8'h27);
        send(8'h00);
        fill_wait();
        status();
        chk("ptr_wrap", 32'h7, {26'h0, rdat[lcd_pkg::ST_PTR_POS +: 6]});
        chk("sub_wrap", 32'h1, {29'h0, rdat[lcd_pkg::ST_SUB_POS +: 3]});
        apb(1'b1, lcd_pkg::OFS_RAM_ADDR, 32'd39);
        apb(1'b0, lcd_pkg::OFS_RAM_DATA, 32'h0);
        chk("ram_last", 32'h0, rdat & 32'h1);
        apb(1'b1, lcd_pkg::OFS_RAM_ADDR, 32'd0);
        apb(1'b0, lcd_pkg::OFS_RAM_DATA, 32'h0);
        chk("ram_gated", 32'h1, rdat & 32'h1);
        // 1:2 with input bank 1: two columns per word at bits 2 and 3
        lcd_byte_src_i.start_xfer();
        send(8'hc2);
        send(8'he0);
        send(8'hfa);
        send(8'h0a);
        send(8'h96);
        fill_wait();
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, lcd_pkg::OFS_RAM_ADDR, 32'ha + 32'(k));
            apb(1'b0, lcd_pkg::OFS_RAM_DATA, 32'h0);
            chk("ram_col0", 32'((8'h96 >> (7 - 2 * k)) & 8'h1), (rdat >> 2) & 32'h1);
            chk("ram_col1", 32'((8'h96 >> (6 - 2 * k)) & 8'h1), (rdat >> 3) & 32'h1);
        end
        status();
        chk("ptr_mux2", 32'he, {26'h0, rdat[lcd_pkg::ST_PTR_POS +: 6]});
        // 1:4 fills all four bits of a word; the input bank no longer applies
        lcd_byte_src_i.start_xfer();
        send(8'hc0);
        send(8'h14);
        send(8'h3c);
        fill_wait();
        apb(1'b1, lcd_pkg::OFS_RAM_ADDR, 32'h14);
        apb(1'b0, lcd_pkg::OFS_RAM_DATA, 32'h0);
        chk("ram_mux4_a", 32'hc, rdat & 32'hf);
        apb(1'b1, lcd_pkg::OFS_RAM_ADDR, 32'h15);
        apb(1'b0, lcd_pkg::OFS_RAM_DATA, 32'h0);
        chk("ram_mux4_b", 32'h3, rdat & 32'hf);
        apb(1'b1, lcd_pkg::OFS_CTRL, 32'h6);
        apb(1'b0, lcd_pkg::OFS_CTRL, 32'h0);
        chk("ctrl_wr", 32'h6, rdat);
        lcd_byte_src_i.start_xfer();
        send(8'hc2);
        chk("disabled", 32'h0, {30'h0, drive_mode});
        final_report();
    end
endmodule // tb_lcd_command_decoder

`default_nettype wire
